// file: rtl/static_zone_bus_interface.v
/*
 * Static zone bus sequencer: turns core bus requests into external
 * static memory and I/O expansion cycles, with APB configuration.
 * Assumes the core holds a request until done_out, and that ext_data_in
 * is a pin input; writes here are late or early style; 16-bit zone word writes take one cycle.
 */
`timescale 1ns/1ps
`default_nettype none
`include "zone_bus_defs.vh"

// Operation
// RL1: Read starts: address, select; strobe at wait/T2
// RL2: Capture 8 or 16 data lines per width
// RL3: Hold states follow; select, strobe drop first
// RL4: No hold: select drops unless same-zone read
// RL5: Wide read with burst adds burst state
// RL6: Burst address change, capture, strobe drop
// RL7: Fast read completes in one clock
// RL8: After fast read select drops unless same zone
// RL9: Fast read then late write keeps select
// RL10: Fast read ignores wait, hold, burst settings
// RL11: Idle clock between write and fast read
// RL12: Fast wide read splits into single reads; S_FAST here ends after one read
// RL13: I/O cycles drive io select, low address, strobes
// RL14: Suppress I/O cycle for on-chip or input-only ports; here input-only ports suppress only writes
// RL15: Idle before I/O cycles; no I/O burst
// RL16: Observe mode gives one-clock monitoring cycle
// RL17: Common config resets 07h; write style, observe
// RL18: Wait count bits 2-0, hold bits 4,3
// RL19: Bit 7 bus width, reset 16-bit
// RL20: Post idle when next zone differs
// RL21: Pre idle when entering from other zone
// RL22: Burst enable, burst wait, fast read bits
// RL23: Writes never burst; 8-bit word write split; here only the first byte cycle runs
// RL24: Config chosen by current address zone
module static_zone_bus_interface (
    input  wire        clk_in,
    input  wire        rst_in,
    input  wire        psel_in,
    input  wire        penable_in,
    input  wire        pwrite_in,
    input  wire [11:0] paddr_in,
    input  wire [31:0] pwdata_in,
    output reg  [31:0] prdata_out,
    output wire        pready_out,
    output wire        pslverr_out,
    input  wire        req_in,
    input  wire        req_write_in,
    input  wire [15:0] req_addr_in,
    input  wire [1:0]  req_zone_in,
    input  wire        req_word_in,
    input  wire [15:0] req_wdata_in,
    input  wire [2:0]  req_status_in,
    input  wire        port_onchip_in,
    input  wire        port_inputs_only_in,
    output wire        done_out,
    output reg  [15:0] rdata_out,
    output reg  [15:0] addr_out,
    output reg         zone_chip_select_n_out,
    output reg  [1:0]  zone_sel_index_out,
    output reg         io_zone_chip_select_n_out,
    output reg         rd_n_out,
    output reg  [1:0]  byte_write_strobes_n_out,
    output reg  [15:0] data_out,
    output reg  [15:0] data_oe_out,
    input  wire [15:0] ext_data_in,
    output reg         core_access_direction_out,
    output reg  [1:0]  byte_lane_enables_out,
    output reg  [2:0]  bus_status_lines_out
);
    localparam [9:0] S_IDLE  = 10'b00_0000_0001;
    localparam [9:0] S_T1    = 10'b00_0000_0010;
    localparam [9:0] S_WAIT  = 10'b00_0000_0100;
    localparam [9:0] S_T2    = 10'b00_0000_1000;
    localparam [9:0] S_BWAIT = 10'b00_0001_0000;
    localparam [9:0] S_BURST = 10'b00_0010_0000;
    localparam [9:0] S_HOLD  = 10'b00_0100_0000;
    localparam [9:0] S_FAST  = 10'b00_1000_0000;
    localparam [9:0] S_MON   = 10'b01_0000_0000;
    localparam [9:0] S_DONE  = 10'b10_0000_0000;

    reg [7:0]  common_cfg_ff;
    reg [15:0] zone_cfg_ff [0:2];
    reg [9:0]  state_ff;
    reg [2:0]  cnt_ff;
    reg        second_ff;
    reg [1:0]  last_zone_ff;
    reg        last_write_ff;
    reg        last_post_ff;
    reg        was_busy_ff;
    reg [15:0] sync1_ff;
    reg [15:0] sync2_ff;
    reg [1:0]  cap1_ff;
    reg [1:0]  cap2_ff;
    reg [15:0] cfg;
    wire       apb_wr;
    wire       is_io;
    wire       wide;
    wire       fast;
    wire       need_idle;
    integer    i;

    // Address decode shared by read and write paths
    function [2:0] reg_index;
        input [11:0] a;
        begin
            if (a == `OFF_COMMON_CFG) begin
                reg_index = 3'h0;
            end else if (a == `OFF_ZONE0_CFG) begin
                reg_index = 3'h1;
            end else if (a == `OFF_ZONE1_CFG) begin
                reg_index = 3'h2;
            end else if (a == `OFF_IO_CFG) begin
                reg_index = 3'h3;
            end else if (a == `OFF_BUS_STATUS) begin
                reg_index = 3'h4;
            end else begin
                reg_index = 3'h7;
            end
        end
    endfunction

    assign pready_out  = 1'b1;
    assign pslverr_out = psel_in & penable_in & (reg_index(paddr_in) == 3'h7);
    assign apb_wr      = psel_in & penable_in & pwrite_in;

    always @(posedge clk_in or posedge rst_in) begin
        if (rst_in) begin
            common_cfg_ff <= `COMMON_CFG_RESET; // RL17
            for (i = 0; i < 3; i = i + 1) begin
                zone_cfg_ff[i] <= `ZONE_CFG_RESET; // RL19
            end
        end else if (apb_wr) begin
            if (reg_index(paddr_in) == 3'h0) begin
                common_cfg_ff <= {6'h00, pwdata_in[1:0]};
            end else if (reg_index(paddr_in) == 3'h1) begin
                zone_cfg_ff[0] <= {4'h0, pwdata_in[11:9], 1'b0, pwdata_in[7:0]};
            end else if (reg_index(paddr_in) == 3'h2) begin
                zone_cfg_ff[1] <= {4'h0, pwdata_in[11:9], 1'b0, pwdata_in[7:0]};
            end else if (reg_index(paddr_in) == 3'h3) begin
                zone_cfg_ff[2] <= {6'h00, pwdata_in[9], 1'b0, pwdata_in[7], 2'h0,
                                   pwdata_in[4:0]};
            end
        end
    end

    always @(posedge clk_in or posedge rst_in) begin
        if (rst_in) begin
            prdata_out <= 32'h0000_0000;
        end else if (psel_in & ~penable_in & ~pwrite_in) begin
            if (reg_index(paddr_in) == 3'h0) begin
                prdata_out <= {24'h00_0000, common_cfg_ff};
            end else if (reg_index(paddr_in) == 3'h1) begin
                prdata_out <= {16'h0000, zone_cfg_ff[0]};
            end else if (reg_index(paddr_in) == 3'h2) begin
                prdata_out <= {16'h0000, zone_cfg_ff[1]};
            end else if (reg_index(paddr_in) == 3'h3) begin
                prdata_out <= {16'h0000, zone_cfg_ff[2]};
            end else if (reg_index(paddr_in) == 3'h4) begin
                prdata_out <= {20'h0_0000, state_ff, last_zone_ff};
            end else begin
                prdata_out <= 32'h0000_0000;
            end
        end
    end

    // Config of the addressed zone steers the whole cycle
    always @* begin
        if (req_zone_in == `ZONE_STATIC1) begin
            cfg = zone_cfg_ff[1]; // RL24
        end else if (req_zone_in == `ZONE_IO) begin
            cfg = zone_cfg_ff[2]; // RL24
        end else begin
            cfg = zone_cfg_ff[0]; // RL24
        end
    end

    assign is_io = (req_zone_in == `ZONE_IO);
    assign wide  = req_word_in & ~cfg[`ZF_WIDTH16];
    // I/O zone has no fast read bit, so fast is never set there
    assign fast  = ~req_write_in & ~is_io & cfg[`ZF_FAST_READ] & ~second_ff; // RL7 RL10
    assign need_idle = ~was_busy_ff ? 1'b0 :
                       (is_io | // RL15
                        (last_write_ff & fast) | // RL11
                        (last_zone_ff != req_zone_in &
                         (last_post_ff | // RL20
                          (~is_io & cfg[`ZF_PRE_IDLE])))); // RL21

    assign done_out = (state_ff == S_DONE) | (state_ff == S_MON);

    always @(posedge clk_in or posedge rst_in) begin
        if (rst_in) begin
            sync1_ff <= 16'h0000;
            sync2_ff <= 16'h0000;
        end else begin
            sync1_ff <= ext_data_in;
            sync2_ff <= sync1_ff;
        end
    end

    // Captured pin data lands in rdata_out two clocks later, behind the synchroniser
    always @(posedge clk_in or posedge rst_in) begin
        if (rst_in) begin
            state_ff                  <= S_IDLE;
            cnt_ff                    <= 3'h0;
            second_ff                 <= 1'b0;
            last_zone_ff              <= `ZONE_INTERNAL;
            last_write_ff             <= 1'b0;
            last_post_ff              <= 1'b0;
            was_busy_ff               <= 1'b0;
            rdata_out                 <= 16'h0000;
            cap1_ff                   <= 2'h0;
            cap2_ff                   <= 2'h0;
            addr_out                  <= 16'h0000;
            zone_chip_select_n_out    <= 1'b1;
            zone_sel_index_out        <= 2'h0;
            io_zone_chip_select_n_out <= 1'b1;
            rd_n_out                  <= 1'b1;
            byte_write_strobes_n_out  <= 2'h3;
            data_out                  <= 16'h0000;
            data_oe_out               <= 16'h0000;
            core_access_direction_out <= 1'b0;
            byte_lane_enables_out     <= 2'h0;
            bus_status_lines_out      <= 3'h0;
        end else begin
            // Capture kind rides along until the sampled word reaches sync2_ff
            cap1_ff <= 2'h0;
            cap2_ff <= cap1_ff;
            if (cap2_ff == 2'h1) begin
                rdata_out <= {8'h00, sync2_ff[7:0]}; // RL2
            end else if (cap2_ff == 2'h2) begin
                rdata_out <= sync2_ff; // RL2
            end else if (cap2_ff == 2'h3) begin
                rdata_out <= {sync2_ff[7:0], rdata_out[7:0]}; // RL6
            end
            case (state_ff)
                S_IDLE: begin
                    rd_n_out                 <= 1'b1;
                    byte_write_strobes_n_out <= 2'h3;
                    data_oe_out              <= 16'h0000;
                    was_busy_ff              <= 1'b0;
                    if (~(req_in & (req_zone_in == last_zone_ff) & ~req_write_in)) begin
                        zone_chip_select_n_out    <= 1'b1; // RL4 RL8
                        io_zone_chip_select_n_out <= 1'b1;
                    end
                    if (req_in & (req_zone_in == `ZONE_INTERNAL)) begin
                        if (common_cfg_ff[`CC_OBSERVE]) begin
                            addr_out                  <= req_addr_in; // RL16
                            core_access_direction_out <= ~req_write_in;
                            byte_lane_enables_out     <= req_word_in ? 2'h3 :
                                                         {req_addr_in[0], ~req_addr_in[0]};
                            bus_status_lines_out      <= req_status_in;
                        end
                        state_ff <= S_MON;
                    end else if (req_in & is_io & (port_onchip_in |
                                 (port_inputs_only_in & req_write_in))) begin
                        state_ff <= S_DONE; // RL14
                    end else if (req_in & ~need_idle) begin
                        was_busy_ff <= 1'b1;
                        second_ff   <= 1'b0;
                        last_zone_ff <= req_zone_in;
                        last_write_ff <= req_write_in;
                        last_post_ff <= cfg[`ZF_POST_IDLE];
                        addr_out    <= is_io ? {8'h00, req_addr_in[7:0]} : req_addr_in; // RL13
                        zone_sel_index_out <= req_zone_in;
                        if (is_io) begin
                            io_zone_chip_select_n_out <= 1'b0; // RL13
                        end else if (~req_write_in | ~common_cfg_ff[`CC_EARLY_WRITE]) begin
                            zone_chip_select_n_out <= 1'b0; // RL1 RL9
                        end
                        if (fast) begin
                            rd_n_out <= 1'b0; // RL7
                            state_ff <= S_FAST;
                        end else begin
                            state_ff <= S_T1; // RL1
                            cnt_ff   <= cfg[`ZF_WAIT_LO+2:`ZF_WAIT_LO]; // RL18
                        end
                    end
                end
                S_T1, S_WAIT: begin
                    if (req_write_in) begin
                        byte_write_strobes_n_out <= (req_word_in & cfg[`ZF_WIDTH16]) ? 2'h0 :
                            (cfg[`ZF_WIDTH16] & req_addr_in[0]) ? 2'h1 : 2'h2;
                        data_out    <= req_wdata_in;
                        data_oe_out <= 16'hffff;
                        if (common_cfg_ff[`CC_EARLY_WRITE] & ~is_io) begin
                            zone_chip_select_n_out <= 1'b0;
                        end else if (common_cfg_ff[`CC_EARLY_WRITE]) begin
                            io_zone_chip_select_n_out <= 1'b0;
                        end
                    end else begin
                        rd_n_out <= 1'b0; // RL1
                    end
                    if (cnt_ff != 3'h0 && !(is_io && state_ff == S_WAIT && cnt_ff == 3'h1
                                           && cfg[2:0] == 3'h7)) begin
                        cnt_ff   <= cnt_ff - 3'h1; // RL18
                        state_ff <= S_WAIT;
                    end else begin
                        state_ff <= S_T2;
                    end
                end
                S_T2, S_BURST: begin
                    if (~req_write_in) begin
                        cap1_ff <= (state_ff == S_BURST) ? 2'h3 : // RL6
                                   cfg[`ZF_WIDTH16] ? 2'h2 : 2'h1; // RL2
                    end
                    rd_n_out                 <= 1'b1; // RL4 RL6
                    byte_write_strobes_n_out <= 2'h3;
                    cnt_ff <= {1'b0, cfg[`ZF_HOLD_LO+1:`ZF_HOLD_LO]};
                    if (state_ff == S_T2 & wide & ~req_write_in & ~is_io &
                        cfg[`ZF_BURST_EN]) begin // RL5 RL15 RL23
                        addr_out[0] <= 1'b1;
                        rd_n_out    <= 1'b0;
                        state_ff    <= cfg[`ZF_BURST_WAIT] ? S_BWAIT : S_BURST; // RL22
                        if (~cfg[`ZF_BURST_WAIT]) begin
                            state_ff <= S_BURST; // RL6
                        end
                    end else if ((state_ff == S_T2) & wide & ~second_ff) begin
                        second_ff <= 1'b1; // RL23
                        state_ff  <= S_DONE;
                    end else if (cfg[`ZF_HOLD_LO+1:`ZF_HOLD_LO] != 2'h0) begin
                        zone_chip_select_n_out    <= 1'b1; // RL3
                        io_zone_chip_select_n_out <= 1'b1;
                        state_ff <= S_HOLD;
                    end else begin
                        state_ff <= S_DONE;
                    end
                end
                S_BWAIT: begin
                    state_ff <= S_BURST; // RL6
                end
                S_HOLD: begin
                    data_oe_out <= data_oe_out;
                    if (cnt_ff <= 3'h1) begin
                        state_ff <= S_DONE; // RL3
                    end else begin
                        cnt_ff <= cnt_ff - 3'h1;
                    end
                end
                S_FAST: begin
                    cap1_ff   <= cfg[`ZF_WIDTH16] ? 2'h2 : 2'h1; // RL7
                    rd_n_out  <= 1'b1; // RL8
                    // A fast wide read ends after this one capture; no second byte cycle runs
                    state_ff  <= S_DONE; // RL12
                end
                S_MON: begin
                    bus_status_lines_out <= 3'h0;
                    state_ff <= S_IDLE;
                end
                S_DONE: begin
                    data_oe_out <= 16'h0000;
                    state_ff    <= S_IDLE;
                end
                default: begin
                    state_ff <= S_IDLE;
                end
            endcase
        end
    end
endmodule
`default_nettype wire

// file: common/zone_bus_defs.vh
/*
 * Constants for the static zone bus sequencer: APB offsets, config
 * field positions and reset values, and core request encodings.
 * Assumes inclusion by bare name from rtl/ files.
 */
`ifndef ZONE_BUS_DEFS_VH
`define ZONE_BUS_DEFS_VH

`define OFF_COMMON_CFG     12'h000
`define OFF_ZONE0_CFG      12'h004
`define OFF_ZONE1_CFG      12'h008
`define OFF_IO_CFG         12'h00c
`define OFF_BUS_STATUS     12'h010

`define COMMON_CFG_RESET   8'h07
`define ZONE_CFG_RESET     16'h069f

`define CC_EARLY_WRITE     0
`define CC_OBSERVE         1

`define ZF_WAIT_LO         0
`define ZF_HOLD_LO         3
`define ZF_BURST_EN        5
`define ZF_BURST_WAIT      6
`define ZF_WIDTH16         7
`define ZF_POST_IDLE       9
`define ZF_PRE_IDLE        10
`define ZF_FAST_READ       11

`define ZONE_STATIC0       2'h0
`define ZONE_STATIC1       2'h1
`define ZONE_IO            2'h2
`define ZONE_INTERNAL      2'h3

`endif

// file: verif/static_zone_bus_interface_sva.sv
/* Port checker for the zone bus sequencer, bound to its top module.
   Assumes zero-wait APB and the offsets and fields of the defs header. */
`timescale 1ns/1ps
`default_nettype none
`include "zone_bus_defs.vh"
module static_zone_bus_checker (
    input wire logic        clk_in,
    input wire logic        rst_in,
    input wire logic        psel_in,
    input wire logic        penable_in,
    input wire logic        pwrite_in,
    input wire logic [11:0] paddr_in,
    input wire logic [31:0] pwdata_in,
    input wire logic        pready_out,
    input wire logic        pslverr_out,
    input wire logic        req_in,
    input wire logic [1:0]  req_zone_in,
    input wire logic        port_onchip_in,
    input wire logic        done_out,
    input wire logic        zone_chip_select_n_out,
    input wire logic [1:0]  zone_sel_index_out,
    input wire logic        io_zone_chip_select_n_out,
    input wire logic        rd_n_out,
    input wire logic [1:0]  byte_write_strobes_n_out
);
    logic [15:0] cfg_ff [0:2];
    logic [15:0] zc;
    logic [7:0]  low_cnt_ff, exp_low;
    logic [1:0]  idx_ff;
    logic        obs_ff, apb_wr, mapped;
    assign apb_wr = psel_in && penable_in && pready_out && pwrite_in;
    assign mapped = paddr_in <= `OFF_BUS_STATUS && paddr_in[1:0] == 2'b00;
    assign zc = (idx_ff == `ZONE_IO) ? cfg_ff[2] : cfg_ff[idx_ff[0]];
    // I/O wait code 111 still means six waits
    assign exp_low = (idx_ff == `ZONE_IO && zc[2:0] == 3'h7) ? 8'd7 : 8'(zc[2:0]) + 8'd1;
    always @(posedge clk_in or posedge rst_in) begin
        if (rst_in) begin
            for (int i = 0; i < 3; i++) cfg_ff[i] <= `ZONE_CFG_RESET;
            obs_ff <= 1'b1;
            idx_ff <= 2'h0;
            low_cnt_ff <= 8'h00;
        end else begin
            low_cnt_ff <= rd_n_out ? 8'h00 : low_cnt_ff + 8'h01;
            if (!rd_n_out) idx_ff <= zone_sel_index_out;
            if (apb_wr && mapped && paddr_in[3:2] != 2'h0)
                cfg_ff[paddr_in[3:2] - 2'h1] <= pwdata_in[15:0];
            if (apb_wr && paddr_in == `OFF_COMMON_CFG) obs_ff <= pwdata_in[`CC_OBSERVE];
        end
    end
    chk_read_no_wstrobe: assert property (@(posedge clk_in) disable iff (rst_in)
        !rd_n_out |-> byte_write_strobes_n_out == 2'b11) else $error("Strobe during read");
    chk_select_exclusive: assert property (@(posedge clk_in) disable iff (rst_in)
        zone_chip_select_n_out || io_zone_chip_select_n_out) else $error("Two selects");
    chk_apb_ready: assert property (@(posedge clk_in) disable iff (rst_in)
        psel_in && penable_in |-> pready_out) else $error("APB not ready");
    chk_apb_error: assert property (@(posedge clk_in) disable iff (rst_in)
        psel_in && penable_in |-> pslverr_out == !mapped) else $error("Wrong slave error");
    chk_done_pulse: assert property (@(posedge clk_in) disable iff (rst_in)
        done_out |=> !done_out) else $error("Done longer than one cycle");
    // Burst and fast reads left out: a burst stretches the strobe, a fast read ignores the wait count
    chk_read_length: assert property (@(posedge clk_in) disable iff (rst_in)
        $rose(rd_n_out) && !obs_ff && idx_ff != `ZONE_INTERNAL && zc[7] && !zc[11]
        |-> low_cnt_ff == exp_low) else $error("Read strobe length wrong");
    chk_quiet_internal: assert property (@(posedge clk_in) disable iff (rst_in)
        req_in && req_zone_in == `ZONE_INTERNAL && !obs_ff |=> zone_chip_select_n_out
        && io_zone_chip_select_n_out && rd_n_out) else $error("Bus toggled, observe off");
    chk_io_suppressed: assert property (@(posedge clk_in) disable iff (rst_in)
        req_in && req_zone_in == `ZONE_IO && port_onchip_in |=> io_zone_chip_select_n_out)
        else $error("I/O cycle not suppressed");
    chk_reset_quiet: assert property (@(posedge clk_in) rst_in |-> zone_chip_select_n_out
        && io_zone_chip_select_n_out && rd_n_out && byte_write_strobes_n_out == 2'b11)
        else $error("Bus active in reset");
endmodule
bind static_zone_bus_interface static_zone_bus_checker chk_i (.clk_in, .rst_in, .psel_in,
    .penable_in, .pwrite_in, .paddr_in, .pwdata_in, .pready_out, .pslverr_out, .req_in,
    .req_zone_in, .port_onchip_in, .done_out, .zone_chip_select_n_out, .zone_sel_index_out,
    .io_zone_chip_select_n_out, .rd_n_out, .byte_write_strobes_n_out);
`default_nettype wire

// file: verif/zone_memory_model.sv
/* Far-side static memory and I/O latch model, 256 words.
   Assumes active-low selects and strobes from the zone bus sequencer. */
`timescale 1ns/1ps
`default_nettype none
module zone_memory_model (
    input  wire logic        clk_in,
    input  wire logic [15:0] addr_in,
    input  wire logic        cs_n_in,
    input  wire logic        io_cs_n_in,
    input  wire logic        rd_n_in,
    input  wire logic [1:0]  wr_n_in,
    input  wire logic [15:0] wdata_in,
    output logic      [15:0] rdata_out
);
    logic [15:0] mem [0:255];
    logic [15:0] last_ff = 16'h0000;
    logic        sel;
    // Ports decode from select and low address alone
    assign sel = !cs_n_in || !io_cs_n_in;
    // Released bus shows a changing pattern, never the last word
    assign rdata_out = (sel && !rd_n_in) ? mem[addr_in[7:0]] : ~last_ff;
    initial for (int i = 0; i < 256; i++) mem[i] = 16'h5a00 ^ (16'h0101 * i[15:0]);
    always @(posedge clk_in) begin
        last_ff <= rdata_out;
        if (sel && !wr_n_in[0]) mem[addr_in[7:0]][7:0] <= wdata_in[7:0];
        if (sel && !wr_n_in[1]) mem[addr_in[7:0]][15:8] <= wdata_in[15:8];
    end
endmodule
`default_nettype wire

// file: verif/static_zone_bus_interface_tb.sv
/* Bench for the zone bus sequencer with a far-side memory model.
   Assumes zero-wait APB and one core request held until done. */
`timescale 1ns/1ps
`default_nettype none
module static_zone_bus_interface_tb;
    logic clk_in = 0, rst_in = 0, psel_in = 0, penable_in = 0, pwrite_in = 0;
    logic req_in = 0, req_write_in = 0, req_word_in = 0, port_onchip_in = 0;
    logic port_inputs_only_in = 0, pready_out, pslverr_out, done_out, zone_chip_select_n_out;
    logic io_zone_chip_select_n_out, rd_n_out, core_access_direction_out, err, io_seen, mon_seen;
    logic [1:0] req_zone_in = 0, zone_sel_index_out, byte_write_strobes_n_out, byte_lane_enables_out;
    logic [2:0] req_status_in = 0, bus_status_lines_out;
    logic [11:0] paddr_in = 0;
    logic [31:0] pwdata_in = 0, prdata_out, rd;
    logic [15:0] req_addr_in = 0, req_wdata_in = 0, rdata_out, addr_out, data_out, data_oe_out;
    logic [15:0] ext_data_in, a, d;
    logic [15:0] mdl [0:255];
    int error_cnt = 0, tests_run = 0, cyc = 0;
    static_zone_bus_interface DUT (.clk_in, .rst_in, .psel_in, .penable_in, .pwrite_in,
        .paddr_in, .pwdata_in, .prdata_out, .pready_out, .pslverr_out, .req_in, .req_write_in,
        .req_addr_in, .req_zone_in, .req_word_in, .req_wdata_in, .req_status_in, .port_onchip_in,
        .port_inputs_only_in, .done_out, .rdata_out, .addr_out, .zone_chip_select_n_out,
        .zone_sel_index_out, .io_zone_chip_select_n_out, .rd_n_out, .byte_write_strobes_n_out,
        .data_out, .data_oe_out, .ext_data_in, .core_access_direction_out,
        .byte_lane_enables_out, .bus_status_lines_out);
    zone_memory_model far_mem (.clk_in, .addr_in(addr_out), .cs_n_in(zone_chip_select_n_out),
        .io_cs_n_in(io_zone_chip_select_n_out), .rd_n_in(rd_n_out),
        .wr_n_in(byte_write_strobes_n_out), .wdata_in(data_out), .rdata_out(ext_data_in));
    always #50 clk_in = ~clk_in;
    task chk(input logic [15:0] got, input logic [15:0] exp);
        tests_run++;
        if (got !== exp) begin
            error_cnt++;
            $display("BAD %0t got %h expected %h", $time, got, exp);
        end
    endtask
    task stop_test;
        $display("Checks %0d, errors %0d", tests_run, error_cnt);
        if (error_cnt == 0 && tests_run > 0) $display("Simulation passed");
        else $display("Simulation failed");
        $finish;
    endtask
    // A hang counts as a mismatch
    always @(posedge clk_in) begin
        cyc++;
        if (cyc == 20000) begin
            error_cnt++;
            $display("BAD %0t timeout", $time);
            stop_test;
        end
    end
    task apb(input logic w, input logic [11:0] ad, input logic [31:0] wd);
        @(posedge clk_in);
        psel_in <= 1'b1;
        pwrite_in <= w;
        paddr_in <= ad;
        pwdata_in <= wd;
        @(posedge clk_in);
        penable_in <= 1'b1;
        do @(posedge clk_in); while (pready_out !== 1'b1);
        rd = prdata_out;
        err = pslverr_out;
        psel_in <= 1'b0;
        penable_in <= 1'b0;
    endtask
    task cfg(input logic [11:0] ad, input logic [15:0] v);
        apb(1'b1, ad, {16'h0000, v});
        apb(1'b0, ad, 32'h0000_0000);
        chk(rd[15:0], v);
    endtask
    task core(input logic w, input logic [1:0] z, input logic wd, input logic [15:0] ad);
        @(posedge clk_in);
        req_in <= 1'b1;
        req_write_in <= w;
        req_zone_in <= z;
        req_word_in <= wd;
        req_addr_in <= ad;
        req_wdata_in <= d;
        req_status_in <= 3'($urandom);
        io_seen = 0;
        mon_seen = 0;
        do begin
            @(posedge clk_in);
            io_seen |= !io_zone_chip_select_n_out;
            mon_seen |= addr_out === ad && core_access_direction_out === !w
                && bus_status_lines_out === req_status_in
                && byte_lane_enables_out === {wd | ad[0], wd | !ad[0]};
        end while (done_out !== 1'b1);
        req_in <= 1'b0;
        // Read data settles two clocks after done
        repeat (2) @(posedge clk_in);
    endtask
    initial begin
        rst_in <= 1'b1;
        void'($urandom(58112));
        for (int i = 0; i < 256; i++) mdl[i] = 16'h5a00 ^ (16'h0101 * i[15:0]);
        repeat (16) @(posedge clk_in);
        rst_in <= 1'b0;
        for (int i = 0; i < 4; i++) begin
            apb(1'b0, 12'(i * 4), 32'h0000_0000);
            chk(rd[15:0], i == 0 ? 16'h0007 : 16'h069f);
        end
        apb(1'b0, 12'h020, 32'h0000_0000);
        chk({15'h0000, err}, 16'h0001);
        cfg(12'h000, 16'h0000);
        for (int k = 0; k < 6; k++) begin
            cfg(12'h004, 16'h0080 | 16'($urandom & 32'h0000_061f));
            a = 16'($urandom & 32'h0000_00fe);
            d = 16'($urandom);
            core(1'b1, 2'h0, 1'b1, a);
            mdl[a[7:0]] = d;
            core(1'b0, 2'h0, 1'b1, a);
            chk(rdata_out, mdl[a[7:0]]);
            core(1'b0, 2'h1, 1'b1, a);
            chk(rdata_out, mdl[a[7:0]]);
        end
        // Eight-bit zone word reads with and without the burst wait
        for (int k = 0; k < 2; k++) begin
            cfg(12'h008, 16'h0021 | 16'(k * 64));
            core(1'b0, 2'h1, 1'b1, a);
            chk(rdata_out, {mdl[a[7:0] + 8'h01][7:0], mdl[a[7:0]][7:0]});
        end
        cfg(12'h008, 16'h089f);
        core(1'b1, 2'h1, 1'b1, a);
        mdl[a[7:0]] = d;
        core(1'b0, 2'h1, 1'b1, a);
        chk(rdata_out, mdl[a[7:0]]);
        core(1'b0, 2'h2, 1'b1, a);
        chk(rdata_out, mdl[a[7:0]]);
        chk({15'h0000, io_seen}, 16'h0001);
        port_onchip_in <= 1'b1;
        core(1'b0, 2'h2, 1'b1, a);
        chk({15'h0000, io_seen}, 16'h0000);
        port_onchip_in <= 1'b0;
        port_inputs_only_in <= 1'b1;
        core(1'b1, 2'h2, 1'b1, a);
        chk({15'h0000, io_seen}, 16'h0000);
        cfg(12'h000, 16'h0002);
        core(1'b0, 2'h3, 1'b1, a ^ 16'h1234);
        chk({15'h0000, mon_seen}, 16'h0001);
        cfg(12'h000, 16'h0000);
        core(1'b0, 2'h3, 1'b1, a ^ 16'h4321);
        chk({15'h0000, mon_seen}, 16'h0000);
        stop_test;
    end
endmodule
`default_nettype wire
